/* design/lhh_defs.svh */
// register offsets, field positions, reset values and timing counts
`ifndef LHH_DEFS_SVH
`define LHH_DEFS_SVH

// ==========================================================
// register map
`define LHH_HOOK_OFS   8'h4F
`define LHH_TAP1_OFS   8'h5D
`define LHH_TAP2_OFS   8'h5E
`define LHH_TAP3_OFS   8'h5F

// ==========================================================
// fields and reset values
`define LHH_FOH_LSB    5
`define LHH_FOH_MSB    6
`define LHH_ONHOOK_SPEED_SECOND_BIT   3
`define LHH_HOOK_WMASK 8'h68
`define LHH_HOOK_RST   8'h20
`define LHH_TAP_RST    8'h00

// ==========================================================
// timing
`define LHH_CLK_PS     25000
`define LHH_TICK_US    100
`define LHH_TICK_CYC   ((`LHH_TICK_US * 1000000) / `LHH_CLK_PS)
`define LHH_MS_TICKS   (1000 / `LHH_TICK_US)
`define LHH_FOH0_MS    512
`define LHH_FOH1_MS    128
`define LHH_FOH2_MS    64
`define LHH_FOH3_MS    8
`define LHH_OHS_MID_US  3000
`define LHH_OHS_LONG_US 26000
`define LHH_OHS_MID_TK  (`LHH_OHS_MID_US / `LHH_TICK_US)
`define LHH_OHS_LONG_TK (`LHH_OHS_LONG_US / `LHH_TICK_US)

`endif

/* design/lhh_pkg.sv */
// types shared by the hook and hybrid block
package lhh_pkg;

    typedef enum logic [3:0] {
        LHH_ONHOOK  = 4'b0001,
        LHH_SEIZE   = 4'b0010,
        LHH_OFFHOOK = 4'b0100,
        LHH_RELEASE = 4'b1000
    } lhh_hook_e;

    typedef struct packed {
        lhh_hook_e          hook;
        logic [12:0]        cnt;
        logic [1:0]         offhook_counter_length;
        logic               onhook_speed_second;
        logic [2:0][7:0]    taps;
        logic [7:0]         rdata;
        logic [2:0]         lsync;
        logic               full;
        logic signed [15:0] rx_hold;
        logic signed [15:0] rx_clean;
        logic               rx_valid;
    } lhh_top_s;

    typedef struct packed {
        logic [3:0][15:0]   x;
        logic signed [15:0] est;
        logic               valid;
    } lhh_fir_s;

    typedef struct packed {
        logic [15:0] cnt;
        logic        tick;
    } lhh_tick_s;

endpackage : lhh_pkg

/* design/lhh_core_if.sv */
// signals between the register bank, tick divider and hybrid filter
`timescale 1ns/1ps
`default_nettype none
interface lhh_core_if;
    logic               tick;
    logic               sample_valid;
    logic signed [15:0] tx_sample;
    logic [3:0][7:0]    taps;
    logic signed [15:0] echo_est;
    logic               echo_valid;

    modport tick_src (output tick);
    modport fir (
        input  sample_valid, tx_sample, taps,
        output echo_est, echo_valid
    );
    modport core (
        input  tick, echo_est, echo_valid,
        output sample_valid, tx_sample, taps
    );
endinterface : lhh_core_if
`default_nettype wire

/* design/lhh_tick_gen.sv */
// free-running divider giving one-cycle timebase ticks
`timescale 1ns/1ps
`default_nettype none
module lhh_tick_gen #(
    parameter int TICK_CYCLES = 4000
) (
    input  wire logic   clock_i,
    input  wire logic   rst_n_i,
    lhh_core_if.tick_src bus
);
    lhh_pkg::lhh_tick_s st_ff;
    lhh_pkg::lhh_tick_s nxt_st;

    always_comb
    begin
        nxt_st      = st_ff;
        nxt_st.tick = 1'b0;
        if (st_ff.cnt == 16'(TICK_CYCLES - 1))
        begin
            nxt_st.cnt  = 16'h0000;
            nxt_st.tick = 1'b1;
        end
        else
        begin
            nxt_st.cnt = st_ff.cnt + 16'h0001;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            st_ff <= '0;
        else
            st_ff <= nxt_st;
    end

    assign bus.tick = st_ff.tick;
endmodule : lhh_tick_gen
`default_nettype wire

/* design/lhh_hybrid_fir.sv */
// four-tap echo estimate over the transmit samples
`timescale 1ns/1ps
`default_nettype none
module lhh_hybrid_fir (
    input  wire logic clock_i,
    input  wire logic rst_n_i,
    lhh_core_if.fir   bus
);
    lhh_pkg::lhh_fir_s st_ff;
    lhh_pkg::lhh_fir_s nxt_st;
    logic signed [25:0] acc;

    // coefficients signed, scale 1/128; a zero tap adds nothing
    always_comb
    begin
        nxt_st       = st_ff;
        nxt_st.valid = 1'b0;
        acc          = '0;
        if (bus.sample_valid)
        begin
            nxt_st.x = {st_ff.x[2:0], bus.tx_sample};
            for (int k = 0; k < 4; k++)
            begin
                acc = acc + 26'($signed(nxt_st.x[k])
                      * $signed(bus.taps[k]));
            end
            nxt_st.est   = acc[22:7];
            nxt_st.valid = 1'b1;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            st_ff <= '0;
        else
            st_ff <= nxt_st;
    end

    assign bus.echo_est   = st_ff.est;
    assign bus.echo_valid = st_ff.valid;

    // ======================================================
    // checks
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    zero_taps_a : assert property (
        bus.sample_valid && bus.taps == '0 |=> bus.echo_est == 16'h0000)
        else $error("zero taps gave a nonzero echo estimate");

    estimate_due_a : assert property (
        bus.sample_valid |=> bus.echo_valid)
        else $error("echo estimate not produced after a sample");
endmodule : lhh_hybrid_fir
`default_nettype wire

/* design/lhh_top.sv */
// hook timing control and hybrid tap registers with their logic
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "lhh_defs.svh"

// ==========================================================
// register bank and hook sequencer
//
// Contract
// - off-hook length codes: 512, 128, 64, 8 ms
// - off-hook length resets to 128 ms, 0x20
// - full part: on-hook speed from three fields
// - on-hook time runs from request clear
// - simpler parts: on-hook always under 0.5 ms
// - three eight-bit read/write tap registers
// - taps shape the hybrid echo estimate
// - zero tap has no effect; taps reset zero
// - taps reachable only with map select set
module lhh_top #(
    parameter int TICK_CYCLES = `LHH_TICK_CYC
) (
    input  wire logic        clock_i,
    input  wire logic        rst_n_i,
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic [7:0]  reg_wdata_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    output var  logic [7:0]  reg_rdata_o,
    input  wire logic        map_select_i,
    input  wire logic        offhook_request_i,
    input  wire logic        onhook_speed_first_i,
    input  wire logic [1:0]  spark_quench_sel_i,
    input  wire logic        line_full_i,
    input  wire logic [15:0] tx_sample_i,
    input  wire logic [15:0] rx_sample_i,
    input  wire logic        sample_valid_i,
    input  wire logic [7:0]  hybrid_tap_four_i,
    output var  logic        loop_close_o,
    output var  logic        offhook_settled_o,
    output var  logic [15:0] rx_clean_o,
    output var  logic        rx_clean_valid_o
);

    // ======================================================
    // helpers
    function automatic logic [1:0] tap_index(input logic [7:0] a);
        case (a)
            `LHH_TAP1_OFS: tap_index = 2'h1;
            `LHH_TAP2_OFS: tap_index = 2'h2;
            `LHH_TAP3_OFS: tap_index = 2'h3;
            default:       tap_index = 2'h0;
        endcase
    endfunction : tap_index

    function automatic logic [12:0] foh_ticks(input logic [1:0] f);
        case (f)
            2'h0:    foh_ticks = 13'(`LHH_FOH0_MS * `LHH_MS_TICKS);
            2'h1:    foh_ticks = 13'(`LHH_FOH1_MS * `LHH_MS_TICKS);
            2'h2:    foh_ticks = 13'(`LHH_FOH2_MS * `LHH_MS_TICKS);
            default: foh_ticks = 13'(`LHH_FOH3_MS * `LHH_MS_TICKS);
        endcase
    endfunction : foh_ticks

    // zero means the fast release, dropped on the next edge
    function automatic logic [12:0] onhook_ticks(
        input logic       full,
        input logic       onhook_speed_first,
        input logic       onhook_speed_second,
        input logic [1:0] sq
    );
        onhook_ticks = 13'h0000;
        if (full)
        begin
            if (onhook_speed_first && sq == 2'h3)
                onhook_ticks = 13'(`LHH_OHS_LONG_TK);
            else if (!onhook_speed_first && onhook_speed_second && sq == 2'h0)
                onhook_ticks = 13'(`LHH_OHS_MID_TK);
        end
    endfunction : onhook_ticks

    // ======================================================
    // submodules
    lhh_core_if core_bus ();

    lhh_tick_gen #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_tick (
        .clock_i (clock_i),
        .rst_n_i (rst_n_i),
        .bus     (core_bus)
    );

    lhh_hybrid_fir u_fir (
        .clock_i (clock_i),
        .rst_n_i (rst_n_i),
        .bus     (core_bus)
    );

    // ======================================================
    // state
    lhh_pkg::lhh_top_s st_ff;
    lhh_pkg::lhh_top_s nxt_st;
    logic [1:0]        wr_idx;
    logic [1:0]        rd_idx;
    logic [12:0]       rel_ticks;

    assign wr_idx    = tap_index(reg_addr_i);
    assign rd_idx    = tap_index(reg_addr_i);
    assign rel_ticks = onhook_ticks(st_ff.full, onhook_speed_first_i,
                                    st_ff.onhook_speed_second, spark_quench_sel_i);

    always_comb
    begin
        nxt_st          = st_ff;
        nxt_st.rdata    = 8'h00;
        nxt_st.rx_valid = 1'b0;

        // line-side variant pin, counted once two stages agree
        nxt_st.lsync = {st_ff.lsync[1:0], line_full_i};
        if (st_ff.lsync[1] == st_ff.lsync[2])
            nxt_st.full = st_ff.lsync[2];

        // register writes
        if (reg_wr_i)
        begin
            if (reg_addr_i == `LHH_HOOK_OFS)
            begin
                nxt_st.offhook_counter_length  = reg_wdata_i[`LHH_FOH_MSB:`LHH_FOH_LSB];
                nxt_st.onhook_speed_second = reg_wdata_i[`LHH_ONHOOK_SPEED_SECOND_BIT];
            end
            else if (wr_idx != 2'h0 && map_select_i)
            begin
                nxt_st.taps[wr_idx - 2'h1] = reg_wdata_i;
            end
        end

        // register reads, data in the following cycle only
        if (reg_rd_i)
        begin
            if (reg_addr_i == `LHH_HOOK_OFS)
            begin
                nxt_st.rdata[`LHH_FOH_MSB:`LHH_FOH_LSB] = st_ff.offhook_counter_length;
                nxt_st.rdata[`LHH_ONHOOK_SPEED_SECOND_BIT] = st_ff.onhook_speed_second;
            end
            else if (rd_idx != 2'h0 && map_select_i)
            begin
                nxt_st.rdata = st_ff.taps[rd_idx - 2'h1];
            end
        end

        // hook sequencer
        case (st_ff.hook)
            lhh_pkg::LHH_ONHOOK:
            begin
                if (offhook_request_i)
                begin
                    nxt_st.hook = lhh_pkg::LHH_SEIZE;
                    nxt_st.cnt  = foh_ticks(st_ff.offhook_counter_length);
                end
            end
            lhh_pkg::LHH_SEIZE, lhh_pkg::LHH_OFFHOOK:
            begin
                if (!offhook_request_i)
                begin
                    // release timing starts at the request clear
                    nxt_st.cnt = rel_ticks;
                    if (rel_ticks == 13'h0000)
                        nxt_st.hook = lhh_pkg::LHH_ONHOOK;
                    else
                        nxt_st.hook = lhh_pkg::LHH_RELEASE;
                end
                else if (st_ff.hook == lhh_pkg::LHH_SEIZE &&
                         core_bus.tick)
                begin
                    if (st_ff.cnt == 13'h0001)
                        nxt_st.hook = lhh_pkg::LHH_OFFHOOK;
                    nxt_st.cnt = st_ff.cnt - 13'h0001;
                end
            end
            lhh_pkg::LHH_RELEASE:
            begin
                if (core_bus.tick)
                begin
                    if (st_ff.cnt == 13'h0001)
                        nxt_st.hook = lhh_pkg::LHH_ONHOOK;
                    nxt_st.cnt = st_ff.cnt - 13'h0001;
                end
            end
            default:
            begin
                nxt_st.hook = lhh_pkg::LHH_ONHOOK;
                nxt_st.cnt  = 13'h0000;
            end
        endcase

        // receive path: subtract the echo estimate
        if (sample_valid_i)
            nxt_st.rx_hold = rx_sample_i;
        if (core_bus.echo_valid)
        begin
            nxt_st.rx_clean = st_ff.rx_hold - core_bus.echo_est;
            nxt_st.rx_valid = 1'b1;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            st_ff      <= '0;
            st_ff.hook <= lhh_pkg::LHH_ONHOOK;
            st_ff.offhook_counter_length  <= 2'(`LHH_HOOK_RST >> `LHH_FOH_LSB);
            st_ff.onhook_speed_second <= 1'b0;
            st_ff.taps <= {3{`LHH_TAP_RST}};
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    // ======================================================
    // outputs
    assign core_bus.sample_valid = sample_valid_i;
    assign core_bus.tx_sample    = tx_sample_i;
    assign core_bus.taps = {hybrid_tap_four_i, st_ff.taps};

    assign reg_rdata_o       = st_ff.rdata;
    assign loop_close_o      = st_ff.hook != lhh_pkg::LHH_ONHOOK;
    assign offhook_settled_o = st_ff.hook == lhh_pkg::LHH_OFFHOOK;
    assign rx_clean_o        = st_ff.rx_clean;
    assign rx_clean_valid_o  = st_ff.rx_valid;

    // ======================================================
    // checks
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    hook_reserved_a : assert property (
        reg_rd_i && reg_addr_i == `LHH_HOOK_OFS
        |=> (reg_rdata_o & ~`LHH_HOOK_WMASK) == 8'h00)
        else $error("reserved hook bits read nonzero");

    hook_roundtrip_a : assert property (
        reg_wr_i && reg_addr_i == `LHH_HOOK_OFS ##1
        reg_rd_i && reg_addr_i == `LHH_HOOK_OFS
        |=> reg_rdata_o == ($past(reg_wdata_i, 2) & `LHH_HOOK_WMASK))
        else $error("hook control readback mismatch");

    tap_gate_a : assert property (
        reg_rd_i && tap_index(reg_addr_i) != 2'h0 && !map_select_i
        |=> reg_rdata_o == 8'h00)
        else $error("tap read without map select");

    tap_locked_a : assert property (
        reg_wr_i && tap_index(reg_addr_i) != 2'h0 && !map_select_i
        |=> $stable(st_ff.taps))
        else $error("tap written without map select");

    tap_write_a : assert property (
        reg_wr_i && reg_addr_i == `LHH_TAP2_OFS && map_select_i
        |=> st_ff.taps[1] == $past(reg_wdata_i))
        else $error("tap two not written");

    seize_len_a : assert property (
        st_ff.hook == lhh_pkg::LHH_ONHOOK && offhook_request_i
        |=> st_ff.cnt == 13'(`LHH_MS_TICKS) *
            ($past(st_ff.offhook_counter_length) == 2'h0 ? 13'd512 :
             $past(st_ff.offhook_counter_length) == 2'h1 ? 13'd128 :
             $past(st_ff.offhook_counter_length) == 2'h2 ? 13'd64 : 13'd8))
        else $error("off-hook counter loaded with wrong length");

    fast_release_a : assert property (
        !st_ff.full && loop_close_o && !offhook_request_i &&
        st_ff.hook != lhh_pkg::LHH_RELEASE |=> !loop_close_o)
        else $error("simpler variant on-hook not immediate");

    mid_release_a : assert property (
        st_ff.full && st_ff.hook == lhh_pkg::LHH_OFFHOOK &&
        !offhook_request_i && !onhook_speed_first_i && st_ff.onhook_speed_second &&
        spark_quench_sel_i == 2'h0
        |=> st_ff.hook == lhh_pkg::LHH_RELEASE && st_ff.cnt == 13'd30)
        else $error("3 ms release not started");

    long_release_a : assert property (
        st_ff.full && st_ff.hook == lhh_pkg::LHH_OFFHOOK &&
        !offhook_request_i && onhook_speed_first_i &&
        spark_quench_sel_i == 2'h3
        |=> st_ff.hook == lhh_pkg::LHH_RELEASE && st_ff.cnt == 13'd260)
        else $error("26 ms release not started");

    hold_line_a : assert property (
        st_ff.hook == lhh_pkg::LHH_OFFHOOK && offhook_request_i
        |=> loop_close_o && offhook_settled_o)
        else $error("line dropped while request held");

    seize_close_a : assert property (
        st_ff.hook == lhh_pkg::LHH_ONHOOK && offhook_request_i
        |=> loop_close_o && !offhook_settled_o)
        else $error("line not seized on request");

    seize_count_a : assert property (
        st_ff.hook == lhh_pkg::LHH_SEIZE && offhook_request_i &&
        core_bus.tick && st_ff.cnt != 13'h0001
        |=> st_ff.hook == lhh_pkg::LHH_SEIZE &&
            st_ff.cnt == $past(st_ff.cnt) - 13'h0001)
        else $error("off-hook counter did not step on tick");

    seize_hold_a : assert property (
        st_ff.hook == lhh_pkg::LHH_SEIZE && offhook_request_i &&
        !core_bus.tick
        |=> $stable(st_ff.cnt) && !offhook_settled_o)
        else $error("off-hook counter moved between ticks");

    release_hold_a : assert property (
        st_ff.hook == lhh_pkg::LHH_RELEASE && !core_bus.tick
        |=> loop_close_o && $stable(st_ff.cnt))
        else $error("release interval cut short");

    full_fast_a : assert property (
        st_ff.full && loop_close_o && !offhook_request_i &&
        st_ff.hook != lhh_pkg::LHH_RELEASE &&
        !(onhook_speed_first_i && spark_quench_sel_i == 2'h3) &&
        !(!onhook_speed_first_i && st_ff.onhook_speed_second &&
          spark_quench_sel_i == 2'h0)
        |=> !loop_close_o)
        else $error("fast on-hook combination not immediate");

    hook_write_a : assert property (
        reg_wr_i && reg_addr_i == `LHH_HOOK_OFS
        |=> st_ff.offhook_counter_length == $past(reg_wdata_i[`LHH_FOH_MSB:`LHH_FOH_LSB])
            && st_ff.onhook_speed_second == $past(reg_wdata_i[`LHH_ONHOOK_SPEED_SECOND_BIT]))
        else $error("hook control fields not written");

    tap_read_a : assert property (
        reg_rd_i && tap_index(reg_addr_i) != 2'h0 && map_select_i
        |=> reg_rdata_o ==
            $past(st_ff.taps[tap_index(reg_addr_i) - 2'h1]))
        else $error("tap readback mismatch");

    unmapped_read_a : assert property (
        reg_rd_i && reg_addr_i != `LHH_HOOK_OFS &&
        tap_index(reg_addr_i) == 2'h0
        |=> reg_rdata_o == 8'h00)
        else $error("unmapped address read nonzero");

    read_idle_a : assert property (
        !reg_rd_i |=> reg_rdata_o == 8'h00)
        else $error("read data outside read cycle");

    echo_path_a : assert property (
        sample_valid_i |=> ##1 rx_clean_valid_o)
        else $error("cleaned receive sample not produced");

endmodule : lhh_top
`default_nettype wire

/* test/lhh_top_bench.sv */
// self-checking bench for the hook timing and hybrid tap registers
`timescale 1ns/1ps
`default_nettype none
`include "lhh_defs.svh"

module lhh_top_bench;

    // ==========================================================
    // signals and design instance
    localparam int TICK = 4;
    logic        clock_i;
    logic        rst_n_i;
    logic [7:0]  reg_addr_i;
    logic [7:0]  reg_wdata_i;
    logic        reg_wr_i;
    logic        reg_rd_i;
    logic [7:0]  reg_rdata_o;
    logic        map_select_i;
    logic        offhook_request_i;
    logic        onhook_speed_first_i;
    logic [1:0]  spark_quench_sel_i;
    logic        line_full_i;
    logic [15:0] tx_sample_i;
    logic [15:0] rx_sample_i;
    logic        sample_valid_i;
    logic [7:0]  hybrid_tap_four_i;
    logic        loop_close_o;
    logic        offhook_settled_o;
    logic [15:0] rx_clean_o;
    logic        rx_clean_valid_o;
    int          fail_count;
    int          n_tests;

    lhh_top #(.TICK_CYCLES(TICK)) lhh_top_inst (
        .clock_i             (clock_i),
        .rst_n_i             (rst_n_i),
        .reg_addr_i          (reg_addr_i),
        .reg_wdata_i         (reg_wdata_i),
        .reg_wr_i            (reg_wr_i),
        .reg_rd_i            (reg_rd_i),
        .reg_rdata_o         (reg_rdata_o),
        .map_select_i        (map_select_i),
        .offhook_request_i   (offhook_request_i),
        .onhook_speed_first_i(onhook_speed_first_i),
        .spark_quench_sel_i  (spark_quench_sel_i),
        .line_full_i         (line_full_i),
        .tx_sample_i         (tx_sample_i),
        .rx_sample_i         (rx_sample_i),
        .sample_valid_i      (sample_valid_i),
        .hybrid_tap_four_i   (hybrid_tap_four_i),
        .loop_close_o        (loop_close_o),
        .offhook_settled_o   (offhook_settled_o),
        .rx_clean_o          (rx_clean_o),
        .rx_clean_valid_o    (rx_clean_valid_o)
    );

    // ==========================================================
    // compare and access tasks
    task automatic chk_bit(input logic got, input logic exp);
        n_tests++;
        if (got !== exp)
        begin
            fail_count++;
            $display("Error at %0t: flag %b, expected %b", $time, got, exp);
        end
    endtask : chk_bit

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            fail_count++;
            $display("Error at %0t: byte %h, expected %h", $time, got, exp);
        end
    endtask : chk8

    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            fail_count++;
            $display("Error at %0t: sample %h, expected %h", $time, got, exp);
        end
    endtask : chk16

    task automatic chk_span(input int got, input int lo, input int hi);
        n_tests++;
        if (got < lo || got > hi)
        begin
            fail_count++;
            $display("Error at %0t: %0d cycles, not in %0d..%0d",
                     $time, got, lo, hi);
        end
    endtask : chk_span

    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        @(posedge clock_i);
        reg_wr_i    <= 1'b1;
        reg_addr_i  <= addr;
        reg_wdata_i <= data;
        @(posedge clock_i);
        reg_wr_i    <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
        @(posedge clock_i);
        reg_rd_i   <= 1'b1;
        reg_addr_i <= addr;
        @(posedge clock_i);
        reg_rd_i   <= 1'b0;
        #1;
        chk8(reg_rdata_o, exp);
    endtask : rd

    // seize, wait for settle, clear request, time the release
    task automatic hook_cycle(input int set_tk, input int rel_tk);
        int n;
        @(posedge clock_i);
        offhook_request_i <= 1'b1;
        @(posedge clock_i);
        #1;
        chk_bit(loop_close_o, 1'b1);
        n = 1;
        while (offhook_settled_o !== 1'b1 && n < 30000)
        begin
            @(posedge clock_i);
            #1;
            n++;
        end
        chk_span(n, (set_tk - 1) * TICK, set_tk * TICK + 3);
        @(posedge clock_i);
        offhook_request_i <= 1'b0;
        n = 0;
        while (loop_close_o !== 1'b0 && n < 30000)
        begin
            @(posedge clock_i);
            #1;
            n++;
        end
        if (rel_tk == 0)
            chk_span(n, 1, 3);
        else
            chk_span(n, (rel_tk - 1) * TICK, rel_tk * TICK + 4);
        repeat (3) @(posedge clock_i);
    endtask : hook_cycle

    task automatic samp(input logic [15:0] tx, input logic [15:0] rx,
                        input logic [15:0] exp);
        @(posedge clock_i);
        sample_valid_i <= 1'b1;
        tx_sample_i    <= tx;
        rx_sample_i    <= rx;
        @(posedge clock_i);
        sample_valid_i <= 1'b0;
        @(posedge clock_i);
        #1;
        chk_bit(rx_clean_valid_o, 1'b1);
        chk16(rx_clean_o, exp);
    endtask : samp

    task automatic final_report;
        $display("comparisons %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : final_report

    // ==========================================================
    // clock and watchdog
    initial
    begin
        clock_i = 1'b0;
        forever #12.5 clock_i = ~clock_i;
    end

    initial
    begin
        repeat (80000) @(posedge clock_i);
        fail_count++;
        $display("Error at %0t: watchdog expired", $time);
        final_report();
    end

    // ==========================================================
    // test sequence
    int foh_ms[4]   = '{`LHH_FOH0_MS, `LHH_FOH1_MS,
                        `LHH_FOH2_MS, `LHH_FOH3_MS};
    logic sp_full[7] = '{1, 1, 1, 1, 1, 0, 0};
    logic sp_ohs[7]  = '{0, 0, 1, 1, 1, 1, 0};
    logic sp_onhook_speed_second[7] = '{0, 1, 0, 1, 0, 1, 1};
    logic [1:0] sp_sq[7] = '{2'h0, 2'h0, 2'h3, 2'h3, 2'h1, 2'h3, 2'h0};
    int   sp_tk[7]   = '{0, 30, 260, 260, 0, 0, 0};

    initial
    begin
        fail_count = 0;
        n_tests = 0;
        rst_n_i = 1'b0;
        reg_addr_i = 8'h00;
        reg_wdata_i = 8'h00;
        reg_wr_i = 1'b0;
        reg_rd_i = 1'b0;
        map_select_i = 1'b1;
        offhook_request_i = 1'b0;
        onhook_speed_first_i = 1'b0;
        spark_quench_sel_i = 2'h0;
        line_full_i = 1'b1;
        tx_sample_i = 16'h0000;
        rx_sample_i = 16'h0000;
        sample_valid_i = 1'b0;
        hybrid_tap_four_i = 8'h00;
        repeat (10) @(posedge clock_i);
        rst_n_i <= 1'b1;

        rd(`LHH_HOOK_OFS, 8'h20);
        rd(`LHH_TAP1_OFS, 8'h00);
        rd(`LHH_TAP2_OFS, 8'h00);
        rd(`LHH_TAP3_OFS, 8'h00);
        wr(`LHH_HOOK_OFS, 8'hFF);
        rd(`LHH_HOOK_OFS, 8'h68);
        wr(`LHH_HOOK_OFS, 8'h97);
        rd(`LHH_HOOK_OFS, 8'h00);
        rd(8'h4E, 8'h00);
        $display("test registers done");

        map_select_i <= 1'b0;
        wr(`LHH_TAP1_OFS, 8'h55);
        rd(`LHH_TAP1_OFS, 8'h00);
        map_select_i <= 1'b1;
        rd(`LHH_TAP1_OFS, 8'h00);
        wr(`LHH_TAP1_OFS, 8'hA5);
        wr(`LHH_TAP2_OFS, 8'h3C);
        wr(`LHH_TAP3_OFS, 8'hFF);
        rd(`LHH_TAP1_OFS, 8'hA5);
        rd(`LHH_TAP2_OFS, 8'h3C);
        rd(`LHH_TAP3_OFS, 8'hFF);
        map_select_i <= 1'b0;
        rd(`LHH_TAP2_OFS, 8'h00);
        map_select_i <= 1'b1;
        $display("test tap access done");

        for (int i = 0; i < 4; i++)
        begin
            wr(`LHH_HOOK_OFS, {1'b0, 2'(i), 5'h00});
            rd(`LHH_HOOK_OFS, {1'b0, 2'(i), 5'h00});
            hook_cycle(foh_ms[i] * `LHH_MS_TICKS, 0);
        end
        $display("test off-hook lengths done");

        for (int i = 0; i < 7; i++)
        begin
            line_full_i <= sp_full[i];
            onhook_speed_first_i <= sp_ohs[i];
            spark_quench_sel_i <= sp_sq[i];
            wr(`LHH_HOOK_OFS, {4'h6, sp_onhook_speed_second[i], 3'h0});
            hook_cycle(`LHH_FOH3_MS * `LHH_MS_TICKS, sp_tk[i]);
        end
        $display("test on-hook speeds done");

        wr(`LHH_TAP1_OFS, 8'h00);
        wr(`LHH_TAP2_OFS, 8'h00);
        wr(`LHH_TAP3_OFS, 8'h00);
        samp(16'h1234, 16'h0F00, 16'h0F00);
        wr(`LHH_TAP1_OFS, 8'h40);
        samp(16'h0100, 16'h1000, 16'h0F80);
        wr(`LHH_TAP1_OFS, 8'h00);
        hybrid_tap_four_i <= 8'h40;
        samp(16'h0200, 16'h0500, 16'h0500);
        samp(16'h0000, 16'h0500, 16'hFBE6);
        samp(16'h0000, 16'h0500, 16'h0480);
        samp(16'h0000, 16'h0500, 16'h0400);
        $display("test hybrid path done");
        final_report();
    end

endmodule : lhh_top_bench
`default_nettype wire
